/* File: shared/bsf_pkg.sv */
// Purpose: Shared types and constants for the bit, shift and flag datapath
// Assumes: 8-bit data, 8-bit status register, 5-bit I/O address space
// Notes: Operation codes are internal to the core decoder and datapath
package bsf_pkg;

  // Data and I/O address widths
  localparam int DATA_W = 8;
  localparam int IO_ADDR_W = 5;

  // Status register bit positions
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam int FLAG_T = 6;
  localparam int FLAG_I = 7;

  // Reset values
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;

  // Issue cycle counts
  localparam int IO_BIT_CYCLES = 2;
  localparam int SINGLE_CYCLES = 1;

  // Operations executed by this datapath
  typedef enum logic [4:0] {
    no_operation_op,
    io_bit_set_op,
    io_bit_clear_op,
    logical_left_shift_op,
    logical_right_shift_op,
    rotate_left_carry_op,
    rotate_right_carry_op,
    arith_right_shift_op,
    nibble_swap_op,
    bit_to_transfer_op,
    transfer_to_bit_op,
    flag_index_set_op,
    flag_index_clear_op,
    carry_set_op,
    carry_clear_op,
    negative_set_op,
    negative_clear_op,
    zero_set_op,
    zero_clear_op,
    global_irq_enable_op,
    global_irq_disable_op,
    sign_flag_set_op,
    sign_flag_clear_op,
    overflow_set_op,
    overflow_clear_op,
    transfer_set_op,
    transfer_clear_op,
    half_carry_set_op,
    half_carry_clear_op,
    sleep_op,
    watchdog_restart_op
  } op_t;

  // One issued instruction
  typedef struct packed {
    op_t op;
    logic [2:0] bit_sel;
    logic [IO_ADDR_W-1:0] io_addr;
    logic [DATA_W-1:0] operand;
  } instr_t;

  // Register write-back towards the register file
  typedef struct packed {
    logic wr_en;
    logic [DATA_W-1:0] data;
  } reg_wb_t;

  // I/O read-modify-write request
  typedef struct packed {
    logic wr_en;
    logic [IO_ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } io_wb_t;

  // One-hot mask for a bit index, used by several units
  function automatic logic [7:0] bit_mask(input logic [2:0] idx);
    bit_mask = 8'h01 << idx;
  endfunction : bit_mask

endpackage : bsf_pkg

/* File: hw/shift_unit.sv */
// Purpose: Combinational shift, rotate and swap with flag results
// Assumes: Old carry is the current status carry bit
// Notes: Flags for ops outside this unit are don't-care and ignored upstream
module shift_unit
  import bsf_pkg::*;
(
  input wire op_t op,
  input wire logic [7:0] din,
  input wire logic carry_in,
  output logic [7:0] dout,
  output logic c_out,
  output logic z_out,
  output logic n_out,
  output logic v_out,
  output logic s_out
);

  // Result and carry selection
  always_comb begin
    dout = din;
    c_out = carry_in;
    case (op)
      logical_left_shift_op: begin
        dout = {din[6:0], 1'b0};
        c_out = din[7];
      end
      logical_right_shift_op: begin
        dout = {1'b0, din[7:1]};
        c_out = din[0];
      end
      rotate_left_carry_op: begin
        dout = {din[6:0], carry_in};
        c_out = din[7];
      end
      rotate_right_carry_op: begin
        dout = {carry_in, din[7:1]};
        c_out = din[0];
      end
      arith_right_shift_op: begin
        // Sign bit kept in place
        dout = {din[7], din[7:1]};
        c_out = din[0];
      end
      nibble_swap_op: begin
        dout = {din[3:0], din[7:4]};
      end
      default: begin
        dout = din;
      end
    endcase
  end

  // Shift flags: V is N xor C after the shift, S is N xor V
  always_comb begin
    z_out = (dout == 8'h00);
    n_out = dout[7];
    v_out = n_out ^ c_out;
    s_out = n_out ^ v_out;
  end

endmodule : shift_unit

/* File: hw/bit_unit.sv */
// Purpose: Single-bit set, clear and insert on a byte
// Assumes: Bit index already decoded by the caller's instruction
// Notes: Purely combinational
module bit_unit
  import bsf_pkg::*;
(
  input wire logic [7:0] din,
  input wire logic [2:0] idx,
  input wire logic value,
  output logic [7:0] dout,
  output logic picked
);

  // Insert value at idx, pass the rest
  always_comb begin
    dout = value ? (din | bit_mask(idx)) : (din & ~bit_mask(idx));
    picked = |(din & bit_mask(idx));
  end

endmodule : bit_unit

/* File: hw/bit_shift_flag_datapath.sv */
// Purpose: Execution datapath for bit, shift, rotate and flag instructions
// Assumes: Decoder holds instr stable while issue_ready is low
// Notes: I/O bit ops are read-modify-write over two cycles
//////////////////////////////////////////////////////////////////////////////
module bit_shift_flag_datapath
  import bsf_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic issue_valid,
  input wire instr_t instr,
  input wire logic [7:0] io_rdata,
  output logic issue_ready,
  output logic [IO_ADDR_W-1:0] io_raddr,
  output io_wb_t io_wb,
  output reg_wb_t reg_wb,
  output logic [7:0] status_q,
  output logic sleep_req,
  output logic wdt_restart
);

  //////////////////////////////////////////////////////////////////////////////
  // Reset release through two flops
  logic rst_s1_q;
  logic rst_n_q;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rst_s1_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q <= rst_s1_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Sequencer for the two-cycle I/O bit ops
  typedef enum logic [0:0] {ST_IDLE, ST_IO_WRITE} seq_t;
  seq_t state_q;
  seq_t state_d;

  // An I/O bit op is accepted in IDLE and written in the second cycle
  logic io_op;
  logic take;
  assign io_op = (instr.op == io_bit_set_op) || (instr.op == io_bit_clear_op);
  assign take = issue_valid && (state_q == ST_IDLE);

  // Next-state decision
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (take && io_op) begin
          state_d = ST_IO_WRITE;
        end
      end
      ST_IO_WRITE: begin
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // Decoder may issue again once the write cycle ends
  assign issue_ready = (state_q == ST_IDLE) && !(issue_valid && io_op);

  //////////////////////////////////////////////////////////////////////////////
  // Shift and bit units
  logic [7:0] sh_dout;
  logic sh_c;
  logic sh_z;
  logic sh_n;
  logic sh_v;
  logic sh_s;

  shift_unit u_shift (
    .op(instr.op),
    .din(instr.operand),
    .carry_in(status_q[FLAG_C]),
    .dout(sh_dout),
    .c_out(sh_c),
    .z_out(sh_z),
    .n_out(sh_n),
    .v_out(sh_v),
    .s_out(sh_s)
  );

  // Register side serves insert; I/O side serves set/clear
  logic [7:0] bit_dout;
  logic bit_picked;
  logic [7:0] io_dout;
  logic io_latched_set_q;
  logic io_latched_set_d;
  logic [2:0] io_bit_q;
  logic [2:0] io_bit_d;
  logic [IO_ADDR_W-1:0] io_addr_q;
  logic [IO_ADDR_W-1:0] io_addr_d;

  bit_unit u_reg_bit (
    .din(instr.operand),
    .idx(instr.bit_sel),
    .value(status_q[FLAG_T]),
    .dout(bit_dout),
    .picked(bit_picked)
  );

  bit_unit u_io_bit (
    .din(io_rdata),
    .idx(io_bit_q),
    .value(io_latched_set_q),
    .dout(io_dout),
    .picked()
  );

  // Read address: live in IDLE, held during the write cycle
  assign io_raddr = (state_q == ST_IDLE) ? instr.io_addr : io_addr_q;

  //////////////////////////////////////////////////////////////////////////////
  // Status, write-back and pulse next values
  logic [7:0] status_d;
  reg_wb_t reg_wb_d;
  io_wb_t io_wb_d;
  logic sleep_d;
  logic wdt_d;

  always_comb begin
    status_d = status_q;
    reg_wb_d = '0;
    io_wb_d = '0;
    sleep_d = 1'b0;
    wdt_d = 1'b0;
    io_bit_d = io_bit_q;
    io_addr_d = io_addr_q;
    io_latched_set_d = io_latched_set_q;
    if (state_q == ST_IO_WRITE) begin
      // Second cycle: write the modified byte, flags untouched
      io_wb_d.wr_en = 1'b1;
      io_wb_d.addr = io_addr_q;
      io_wb_d.data = io_dout;
    end else if (take) begin
      case (instr.op)
        io_bit_set_op, io_bit_clear_op: begin
          // Capture target; value is applied next cycle
          io_bit_d = instr.bit_sel;
          io_addr_d = instr.io_addr;
          io_latched_set_d = (instr.op == io_bit_set_op);
        end
        logical_left_shift_op, logical_right_shift_op, arith_right_shift_op,
        rotate_left_carry_op, rotate_right_carry_op: begin
          reg_wb_d.wr_en = 1'b1;
          reg_wb_d.data = sh_dout;
          status_d[FLAG_C] = sh_c;
          status_d[FLAG_Z] = sh_z;
          status_d[FLAG_N] = sh_n;
          status_d[FLAG_V] = sh_v;
          status_d[FLAG_S] = sh_s;
        end
        nibble_swap_op: begin
          reg_wb_d.wr_en = 1'b1;
          reg_wb_d.data = sh_dout;
        end
        bit_to_transfer_op: begin
          status_d[FLAG_T] = bit_picked;
        end
        transfer_to_bit_op: begin
          reg_wb_d.wr_en = 1'b1;
          reg_wb_d.data = bit_dout;
        end
        flag_index_set_op: status_d = status_q | bit_mask(instr.bit_sel);
        flag_index_clear_op: status_d = status_q & ~bit_mask(instr.bit_sel);
        carry_set_op: status_d[FLAG_C] = 1'b1;
        carry_clear_op: status_d[FLAG_C] = 1'b0;
        negative_set_op: status_d[FLAG_N] = 1'b1;
        negative_clear_op: status_d[FLAG_N] = 1'b0;
        zero_set_op: status_d[FLAG_Z] = 1'b1;
        zero_clear_op: status_d[FLAG_Z] = 1'b0;
        overflow_set_op: status_d[FLAG_V] = 1'b1;
        overflow_clear_op: status_d[FLAG_V] = 1'b0;
        half_carry_set_op: status_d[FLAG_H] = 1'b1;
        half_carry_clear_op: status_d[FLAG_H] = 1'b0;
        transfer_set_op: status_d[FLAG_T] = 1'b1;
        transfer_clear_op: status_d[FLAG_T] = 1'b0;
        sign_flag_set_op: status_d[FLAG_S] = 1'b1;
        sign_flag_clear_op: status_d[FLAG_S] = 1'b0;
        global_irq_enable_op: status_d[FLAG_I] = 1'b1;
        global_irq_disable_op: status_d[FLAG_I] = 1'b0;
        sleep_op: sleep_d = 1'b1;
        watchdog_restart_op: wdt_d = 1'b1;
        default: begin
          // No-op and unknown: nothing changes
          status_d = status_q;
        end
      endcase
    end
  end

  // Register all state; outputs other than issue_ready and io_raddr come straight from flops
  always_ff @(posedge clk_sys or negedge rst_n_q) begin
    if (!rst_n_q) begin
      state_q <= ST_IDLE;
      status_q <= STATUS_RESET;
      reg_wb <= '0;
      io_wb <= '0;
      sleep_req <= 1'b0;
      wdt_restart <= 1'b0;
      io_bit_q <= 3'h0;
      io_addr_q <= '0;
      io_latched_set_q <= 1'b0;
    end else begin
      state_q <= state_d;
      status_q <= status_d;
      reg_wb <= reg_wb_d;
      io_wb <= io_wb_d;
      sleep_req <= sleep_d;
      wdt_restart <= wdt_d;
      io_bit_q <= io_bit_d;
      io_addr_q <= io_addr_d;
      io_latched_set_q <= io_latched_set_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  // Sleep issue seen by the checks; back-to-back sleeps keep the request high
  logic sleep_take;
  assign sleep_take = take && (instr.op == sleep_op);

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n_q);

  a_io_set_bit: assert property (
    take && instr.op == io_bit_set_op |-> ##2 io_wb.wr_en && io_wb.data[$past(instr.bit_sel, 2)]
  ) else $error("I/O set did not write a one two cycles later");
  a_io_clear_bit: assert property (
    take && instr.op == io_bit_clear_op |-> ##2 io_wb.wr_en && !io_wb.data[$past(instr.bit_sel, 2)]
  ) else $error("I/O clear did not write a zero two cycles later");
  a_io_flags_kept: assert property (
    state_q == ST_IO_WRITE |=> $stable(status_q)
  ) else $error("Status changed during I/O bit op");
  a_lsl_result: assert property (
    take && instr.op == logical_left_shift_op |=>
      reg_wb.data == {$past(instr.operand[6:0]), 1'b0} && status_q[FLAG_C] == $past(instr.operand[7])
  ) else $error("Left shift result or carry wrong");
  a_lsr_result: assert property (
    take && instr.op == logical_right_shift_op |=> reg_wb.data[7] == 1'b0 && !status_q[FLAG_N]
  ) else $error("Right shift did not clear top bit");
  a_rol_carry: assert property (
    take && instr.op == rotate_left_carry_op |=> reg_wb.data[0] == $past(status_q[FLAG_C])
  ) else $error("Rotate left did not take old carry");
  a_ror_carry: assert property (
    take && instr.op == rotate_right_carry_op |=> reg_wb.data[7] == $past(status_q[FLAG_C])
  ) else $error("Rotate right did not take old carry");
  a_asr_sign: assert property (
    take && instr.op == arith_right_shift_op |=> reg_wb.data[7] == $past(instr.operand[7])
  ) else $error("Arithmetic shift lost sign");
  a_swap_flags: assert property (
    take && instr.op == nibble_swap_op |=> $stable(status_q) && reg_wb.wr_en
  ) else $error("Swap changed flags or did not write");
  a_bst_copy: assert property (
    take && instr.op == bit_to_transfer_op |=>
      status_q[FLAG_T] == 1'($past(instr.operand) >> $past(instr.bit_sel))
  ) else $error("Transfer flag not loaded from register bit");
  a_bld_copy: assert property (
    take && instr.op == transfer_to_bit_op |=> $stable(status_q) && reg_wb.wr_en
  ) else $error("Bit load changed flags or did not write");
  a_carry_set: assert property (
    take && instr.op == carry_set_op |=> status_q == ($past(status_q) | 8'h01)
  ) else $error("Carry set touched other flags");
  a_half_clear: assert property (
    take && instr.op == half_carry_clear_op |=> status_q == ($past(status_q) & 8'hDF)
  ) else $error("Half-carry clear wrong");
  a_sign_set: assert property (
    take && instr.op == sign_flag_set_op |=> status_q == ($past(status_q) | 8'h10)
  ) else $error("Sign set wrong");
  a_sleep_pulse: assert property (
    sleep_take |=> sleep_req && $stable(status_q) ##1 (!sleep_req || $past(sleep_take))
  ) else $error("Sleep request not a single pulse");
  a_wdt_pulse: assert property (
    take && instr.op == watchdog_restart_op |=> wdt_restart && $stable(status_q)
  ) else $error("Watchdog restart not signalled");
  a_index_set: assert property (
    take && instr.op == flag_index_set_op |=> status_q[$past(instr.bit_sel)]
  ) else $error("Indexed flag set failed");
  a_nop_quiet: assert property (
    take && instr.op == no_operation_op |=> $stable(status_q) && !reg_wb.wr_en && !io_wb.wr_en
  ) else $error("No-op changed state");

  c_io_set: cover property (take && instr.op == io_bit_set_op ##2 io_wb.wr_en);
  c_rotate: cover property (take && instr.op == rotate_left_carry_op);
  c_bld: cover property (take && instr.op == transfer_to_bit_op);
  c_sleep: cover property (sleep_req);

endmodule : bit_shift_flag_datapath

/* File: tb/bit_shift_flag_datapath_bench.sv */
// Purpose: Self-checking bench for the bit, shift and flag datapath
// Assumes: I/O space is a bench array read combinationally through io_raddr
// Notes: A bench model with integers predicts every result; stimulus is random
module bit_shift_flag_datapath_bench import bsf_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;

  //////////////////////////////////////////////////////////////////////////////
  // Design connections
  logic clk_sys; // Core clock, 25 MHz
  logic reset_n; // Active low reset
  logic issue_valid; // Instruction presented
  instr_t instr; // Instruction fields
  logic [7:0] io_rdata; // Read data of the addressed I/O location
  logic issue_ready;
  logic [IO_ADDR_W-1:0] io_raddr;
  io_wb_t io_wb;
  reg_wb_t reg_wb;
  logic [7:0] status_q;
  logic sleep_req;
  logic wdt_restart;
  logic [7:0] io_mem [0:31]; // Bench copy of the I/O space
  int bad_count; // Mismatches seen
  int total_checks; // Comparisons made
  logic [31:0] seed; // Random state
  int exp_st; // Model of the status register

  assign io_rdata = io_mem[io_raddr];

  bit_shift_flag_datapath bit_shift_flag_datapath_i (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .issue_valid(issue_valid),
    .instr(instr),
    .io_rdata(io_rdata),
    .issue_ready(issue_ready),
    .io_raddr(io_raddr),
    .io_wb(io_wb),
    .reg_wb(reg_wb),
    .status_q(status_q),
    .sleep_req(sleep_req),
    .wdt_restart(wdt_restart)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Clock generation, 40 ns period
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  // Xorshift step for repeatable random values
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s;
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs

  // Status bit touched by a flag instruction, or -1 for any other op
  function automatic int flag_idx(input op_t op, input logic [2:0] sel);
    case (op)
      flag_index_set_op, flag_index_clear_op: return int'(sel);
      carry_set_op, carry_clear_op: return FLAG_C;
      negative_set_op, negative_clear_op: return FLAG_N;
      zero_set_op, zero_clear_op: return FLAG_Z;
      overflow_set_op, overflow_clear_op: return FLAG_V;
      sign_flag_set_op, sign_flag_clear_op: return FLAG_S;
      half_carry_set_op, half_carry_clear_op: return FLAG_H;
      transfer_set_op, transfer_clear_op: return FLAG_T;
      global_irq_enable_op, global_irq_disable_op: return FLAG_I;
      default: return -1;
    endcase
  endfunction : flag_idx

  // Whether a flag instruction sets rather than clears
  function automatic int is_set(input op_t op);
    return int'(op inside {flag_index_set_op, carry_set_op, negative_set_op, zero_set_op,
      overflow_set_op, sign_flag_set_op, half_carry_set_op, transfer_set_op,
      global_irq_enable_op});
  endfunction : is_set

  //////////////////////////////////////////////////////////////////////////////
  // Verdict and comparison
  task end_of_test();
    if (bad_count == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_of_test

  task check(input logic [7:0] seen, input int exp, input string what);
    total_checks++;
    if (seen !== 8'(exp)) begin
      bad_count++;
      $display("Error at %0t: %s seen %0h expected %0h", $time, what, seen, 8'(exp));
    end
  endtask : check

  //////////////////////////////////////////////////////////////////////////////
  // Single-cycle op: present, let it be taken, compare the cycle after
  task run_op(input op_t op, input logic [2:0] sel, input logic [7:0] d);
    int c, r, wr, sh, n, v, fi;
    c = (exp_st >> FLAG_C) & 1;
    r = d;
    wr = 1;
    sh = 1;
    case (op)
      logical_left_shift_op: begin r = (d << 1) & 255; c = d[7]; end
      logical_right_shift_op: begin r = d >> 1; c = d[0]; end
      rotate_left_carry_op: begin r = ((d << 1) & 255) | c; c = d[7]; end
      rotate_right_carry_op: begin r = (d >> 1) | (c << 7); c = d[0]; end
      arith_right_shift_op: begin r = (d >> 1) | (d & 128); c = d[0]; end
      nibble_swap_op: begin r = {d[3:0], d[7:4]}; sh = 0; end
      transfer_to_bit_op: begin
        r = ((exp_st >> FLAG_T) & 1) ? (d | (1 << sel)) : (d & ~(1 << sel));
        sh = 0;
      end
      default: begin wr = 0; sh = 0; end
    endcase
    // Shift family refreshes the low five flags, upper three stay
    if (sh == 1) begin
      n = (r >> 7) & 1;
      v = n ^ c;
      exp_st = (exp_st & 'hE0) | c | (int'(r == 0) << 1) | (n << 2) | (v << 3)
        | ((n ^ v) << 4);
    end
    if (op == bit_to_transfer_op) begin
      exp_st = (exp_st & ~(1 << FLAG_T)) | (int'(d[sel]) << FLAG_T);
    end
    fi = flag_idx(op, sel);
    if (fi >= 0) begin
      exp_st = (exp_st & ~(1 << fi)) | (is_set(op) << fi);
    end
    issue_valid = 1'b1;
    instr = '{op: op, bit_sel: sel, io_addr: 5'(seed[12:8]), operand: d};
    @(posedge clk_sys);
    #1;
    check(8'(reg_wb.wr_en), wr, "register write");
    if (wr == 1) begin
      check(reg_wb.data, r, "register data");
    end
    check(status_q, exp_st, "status");
    check(8'(sleep_req), int'(op == sleep_op), "sleep pulse");
    check(8'(wdt_restart), int'(op == watchdog_restart_op), "watchdog pulse");
    check(8'(io_wb.wr_en), 0, "stray io write");
    check(8'(issue_ready), 1, "ready after single op");
  endtask : run_op

  //////////////////////////////////////////////////////////////////////////////
  // I/O bit op: read-modify-write, write pulse two edges after presenting
  task run_io(input op_t op, input logic [2:0] sel, input logic [4:0] a);
    int n, exp;
    exp = (op == io_bit_set_op) ? (io_mem[a] | (1 << sel)) : (io_mem[a] & ~(1 << sel));
    issue_valid = 1'b1;
    instr = '{op: op, bit_sel: sel, io_addr: a, operand: seed[7:0]};
    @(posedge clk_sys);
    #1;
    // Lowered in the write cycle so the op is not taken twice
    issue_valid = 1'b0;
    check(8'(issue_ready), 0, "ready in write cycle");
    n = 1;
    while (io_wb.wr_en !== 1'b1) begin
      if (n > 4) begin
        bad_count++;
        end_of_test();
      end
      @(posedge clk_sys);
      #1;
      n++;
    end
    check(8'(n), IO_BIT_CYCLES, "io cycles");
    check(8'(issue_ready), 1, "ready after io write");
    check(8'(io_wb.addr), a, "io address");
    check(io_wb.data, exp, "io data");
    check(status_q, exp_st, "status after io");
    check(8'(reg_wb.wr_en), 0, "register write on io");
    io_mem[a] = 8'(exp);
  endtask : run_io

  // Dispatch one instruction by kind
  task do_op(input op_t op, input logic [31:0] rnd);
    if (op == io_bit_set_op || op == io_bit_clear_op) begin
      run_io(op, rnd[18:16], rnd[12:8]);
    end else begin
      run_op(op, rnd[18:16], rnd[7:0]);
    end
  endtask : do_op

  // Reset held six cycles, then three edges for the internal synchroniser
  task do_reset();
    reset_n = 1'b0;
    issue_valid = 1'b0;
    exp_st = STATUS_RESET;
    repeat (6) @(posedge clk_sys);
    #1;
    check(status_q, STATUS_RESET, "status in reset");
    check(8'(reg_wb.wr_en), 0, "write in reset");
    reset_n = 1'b1;
    repeat (3) @(posedge clk_sys);
    #1;
  endtask : do_reset

  //////////////////////////////////////////////////////////////////////////////
  // Main sequence: every op once, random back-to-back run, reset, another run
  initial begin
    reset_n = 1'b0;
    issue_valid = 1'b0;
    instr = '0;
    bad_count = 0;
    total_checks = 0;
    seed = 32'h8BB1E792;
    for (int k = 0; k < 32; k++) begin
      seed = xs(seed);
      io_mem[k] = seed[7:0];
    end
    do_reset();
    for (int k = 0; k < 31; k++) begin
      seed = xs(seed);
      do_op(op_t'(k), seed);
    end
    for (int k = 0; k < 600; k++) begin
      seed = xs(seed);
      if (k == 300) begin
        do_reset();
      end
      // Occasional idle gap; otherwise ops run back to back
      if (seed[31:29] == 3'h0) begin
        issue_valid = 1'b0;
        @(posedge clk_sys);
        #1;
      end
      do_op(op_t'(seed[4:0] % 31), xs(seed));
    end
    end_of_test();
  end

endmodule : bit_shift_flag_datapath_bench
